//--- drive_state_io_indicator.sv
// Purpose: operating state indication on two status outputs and state
//          transitions from enable and fault-reset inputs
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   upstream events (errors, fieldbus, halt done) arrive as pulses
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1 - no-fault is high in Ready, Switched On and Operation Enabled only.
// RULE2 - active indication is high only in Operation Enabled.
// RULE3 - after reset output zero shows no-fault and output one shows active.
// RULE4 - a class 1 panel error reset returns Quick Stop to Operation Enabled.
// RULE5 - a class 2 or 3 panel error reset moves Fault to Switch On Disabled.
// RULE6 - an enable rising edge requests the enable transition.
// RULE7 - an enable falling edge disables from Operation Enabled or Quick Stop.
// RULE8 - enable edges act only on an input assigned the enable function.
// RULE9 - a two-bit setting picks no, falling or rising enable fault reset.
// RULE10 - a new enable fault-reset setting applies at the next stage enable.
// RULE11 - a fault-reset rising edge clears Fault or resumes a class 1 stop.
// RULE12 - fault-reset edges act only on an input assigned that function.
// RULE13 - a disable in Operation Enabled halts first or cuts as selected.
// RULE14 - a disable in Quick Stop cuts the power stage at once.
// RULE15 - the controller removes an error's cause before a fault reset.
// RULE16 - both inputs are synchronised; each enable edge and each fault-reset rising edge gives a one-cycle event.
module drive_state_io_indicator (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic        i_enable_pin,
    input  wire logic        i_fault_reset_pin,
    input  wire logic        i_enable_fn_assigned,
    input  wire logic        i_fault_reset_fn_assigned,
    input  wire logic        i_panel_error_reset,
    input  wire logic        i_error_class1,
    input  wire logic        i_error_class23,
    input  wire logic        i_fault_react_done,
    input  wire logic        i_init_done,
    input  wire logic        i_ready_request,
    input  wire logic        i_halt_done,
    input  wire logic        i_disable_reaction_select,
    input  wire logic [1:0]  i_out_zero_fn,
    input  wire logic [1:0]  i_out_one_fn,
    input  wire logic        i_out_fn_write,
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    output logic             o_status_output_zero,
    output logic             o_status_output_one,
    output logic             o_power_stage_on,
    output logic             o_halt_active,
    output logic      [3:0]  o_op_state
);

    // ----------------------------------------------------------------
    // input synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [2:0] ena_sync_r;
    logic [2:0] fres_sync_r;

    // third stage keeps the previous sample for edge compare
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ena_sync_r  <= 3'h0;
            fres_sync_r <= 3'h0;
        end else if (i_clk_en) begin
            ena_sync_r  <= {ena_sync_r[1:0], i_enable_pin};        // RULE16
            fres_sync_r <= {fres_sync_r[1:0], i_fault_reset_pin};  // RULE16
        end
    end

    // edges only from the second and third stage, never the first
    wire ena_rise  = ena_sync_r[1] & ~ena_sync_r[2] & i_clk_en;   // RULE16
    wire ena_fall  = ~ena_sync_r[1] & ena_sync_r[2] & i_clk_en;   // RULE16
    wire fres_rise = fres_sync_r[1] & ~fres_sync_r[2] & i_clk_en; // RULE16

    wire ena_rise_ev  = ena_rise & i_enable_fn_assigned;          // RULE8
    wire ena_fall_ev  = ena_fall & i_enable_fn_assigned;          // RULE8
    wire fres_rise_ev = fres_rise & i_fault_reset_fn_assigned;    // RULE12

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    logic [15:0]                   cfg_r;
    logic [1:0]                    fres_sel_act_r;
    logic                          class1_stop_r;
    drive_state_io_pkg::op_state_t state_r;
    drive_state_io_pkg::op_state_t state_nxt;

    wire cfg_hit = (i_reg_addr == drive_state_io_pkg::ENA_FRES_CFG_OFFSET);
    wire cfg_wr  = i_reg_write & cfg_hit & i_clk_en;

    // stored value only; the active copy is taken at power stage enable
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cfg_r <= drive_state_io_pkg::ENA_FRES_CFG_RESET;     // RULE9
        end else if (cfg_wr) begin
            cfg_r <= i_reg_wdata;
        end
    end

    wire [1:0] cfg_sel =
        cfg_r[drive_state_io_pkg::ENA_FRES_SEL_MSB:
              drive_state_io_pkg::ENA_FRES_SEL_LSB];

    wire stage_enabling = (state_nxt == drive_state_io_pkg::ST_OP_ENABLED)
                        & (state_r == drive_state_io_pkg::ST_SWITCHED_ON);

    // latching at enable avoids a mid-run change of reset behaviour
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            fres_sel_act_r <= drive_state_io_pkg::FRES_OFF;
        end else if (i_clk_en && stage_enabling) begin
            fres_sel_act_r <= cfg_sel;                            // RULE10
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_clk_en && i_reg_read) begin
            o_reg_rdata <= cfg_hit ? cfg_r : 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // fault reset sources
    // ----------------------------------------------------------------
    wire ena_fres = ((fres_sel_act_r == drive_state_io_pkg::RESET_ON_FALL)
                     & ena_fall_ev)
                  | ((fres_sel_act_r == drive_state_io_pkg::RESET_ON_RISE)
                     & ena_rise_ev);                              // RULE9
    wire panel_rst = i_panel_error_reset & i_clk_en;
    wire fault_rst = fres_rise_ev | ena_fres | panel_rst;         // RULE11

    // ----------------------------------------------------------------
    // operating state machine
    // ----------------------------------------------------------------
    logic halt_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            drive_state_io_pkg::ST_START: begin
                state_nxt = drive_state_io_pkg::ST_NOT_READY;
            end
            drive_state_io_pkg::ST_NOT_READY: begin
                if (i_init_done) begin
                    state_nxt = drive_state_io_pkg::ST_SW_ON_DIS;
                end
            end
            drive_state_io_pkg::ST_SW_ON_DIS: begin
                if (i_ready_request) begin
                    state_nxt = drive_state_io_pkg::ST_READY;
                end
            end
            drive_state_io_pkg::ST_READY: begin
                if (ena_rise_ev) begin
                    state_nxt = drive_state_io_pkg::ST_SWITCHED_ON;
                end
            end
            drive_state_io_pkg::ST_SWITCHED_ON: begin
                if (ena_fall_ev) begin
                    state_nxt = drive_state_io_pkg::ST_SW_ON_DIS;
                end else begin
                    state_nxt = drive_state_io_pkg::ST_OP_ENABLED; // RULE6
                end
            end
            drive_state_io_pkg::ST_OP_ENABLED: begin
                if (i_error_class1) begin
                    state_nxt = drive_state_io_pkg::ST_QUICK_STOP;
                end else if (halt_r && i_halt_done) begin
                    state_nxt = drive_state_io_pkg::ST_SW_ON_DIS;  // RULE13
                end else if (ena_fall_ev && !halt_r &&
                             i_disable_reaction_select ==
                             drive_state_io_pkg::DISABLE_IMMEDIATE) begin
                    state_nxt = drive_state_io_pkg::ST_SW_ON_DIS;  // RULE7
                end
            end
            drive_state_io_pkg::ST_QUICK_STOP: begin
                if (ena_fall_ev) begin
                    state_nxt = drive_state_io_pkg::ST_SW_ON_DIS;  // RULE14
                end else if (fault_rst && class1_stop_r) begin
                    state_nxt = drive_state_io_pkg::ST_OP_ENABLED; // RULE4
                end
            end
            drive_state_io_pkg::ST_FAULT_REACT: begin
                if (i_fault_react_done) begin
                    state_nxt = drive_state_io_pkg::ST_FAULT;
                end
            end
            drive_state_io_pkg::ST_FAULT: begin
                if (fault_rst) begin
                    state_nxt = drive_state_io_pkg::ST_SW_ON_DIS;  // RULE5
                end
            end
            default: begin
                state_nxt = drive_state_io_pkg::ST_START;
            end
        endcase
        // class 2/3 errors override from any non-fault state
        if (i_error_class23 &&
            state_r != drive_state_io_pkg::ST_FAULT &&
            state_r != drive_state_io_pkg::ST_FAULT_REACT) begin
            state_nxt = drive_state_io_pkg::ST_FAULT_REACT;
        end
    end

    // gate all upstream inputs, pulses included, by the clock enable
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= drive_state_io_pkg::ST_START;
        end else if (i_clk_en) begin
            state_r <= state_nxt;
        end
    end

    // quick stop from a class 1 error is resumable by fault reset
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            class1_stop_r <= 1'b0;
        end else if (i_clk_en) begin
            if (state_r == drive_state_io_pkg::ST_OP_ENABLED &&
                i_error_class1) begin
                class1_stop_r <= 1'b1;
            end else if (state_nxt != drive_state_io_pkg::ST_QUICK_STOP) begin
                class1_stop_r <= 1'b0;
            end
        end
    end

    // halt deceleration pending before the power stage is cut
    wire halt_start = ena_fall_ev &
        (state_r == drive_state_io_pkg::ST_OP_ENABLED) &
        (i_disable_reaction_select == drive_state_io_pkg::DISABLE_AFTER_HALT);

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            halt_r <= 1'b0;
        end else if (i_clk_en) begin
            if (state_nxt != drive_state_io_pkg::ST_OP_ENABLED) begin
                halt_r <= 1'b0;
            end else if (halt_start) begin
                halt_r <= 1'b1;                                   // RULE13
            end
        end
    end

    // ----------------------------------------------------------------
    // status output routing
    // ----------------------------------------------------------------
    logic [1:0] out_zero_fn_r;
    logic [1:0] out_one_fn_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            out_zero_fn_r <= drive_state_io_pkg::OUT_ZERO_FN_RESET; // RULE3
            out_one_fn_r  <= drive_state_io_pkg::OUT_ONE_FN_RESET;  // RULE3
        end else if (i_clk_en && i_out_fn_write) begin
            out_zero_fn_r <= i_out_zero_fn;
            out_one_fn_r  <= i_out_one_fn;
        end
    end

    // indication decoded from the next state so outputs track state_r
    wire no_fault_nxt = (state_nxt == drive_state_io_pkg::ST_READY)
                      | (state_nxt == drive_state_io_pkg::ST_SWITCHED_ON)
                      | (state_nxt == drive_state_io_pkg::ST_OP_ENABLED); // RULE1
    wire active_nxt   = (state_nxt == drive_state_io_pkg::ST_OP_ENABLED); // RULE2

    wire zero_val = (out_zero_fn_r == drive_state_io_pkg::OUT_FN_NO_FAULT)
                  ? no_fault_nxt
                  : (out_zero_fn_r == drive_state_io_pkg::OUT_FN_ACTIVE)
                  & active_nxt;
    wire one_val  = (out_one_fn_r == drive_state_io_pkg::OUT_FN_NO_FAULT)
                  ? no_fault_nxt
                  : (out_one_fn_r == drive_state_io_pkg::OUT_FN_ACTIVE)
                  & active_nxt;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_status_output_zero <= 1'b0;
            o_status_output_one  <= 1'b0;
            o_power_stage_on     <= 1'b0;
            o_halt_active        <= 1'b0;
            o_op_state           <= drive_state_io_pkg::ST_START;
        end else if (i_clk_en) begin
            o_status_output_zero <= zero_val;                     // RULE1
            o_status_output_one  <= one_val;                      // RULE2
            o_power_stage_on     <= active_nxt |
                (state_nxt == drive_state_io_pkg::ST_QUICK_STOP);
            o_halt_active        <= (halt_start | halt_r) &
                (state_nxt == drive_state_io_pkg::ST_OP_ENABLED);
            o_op_state           <= state_nxt;
        end
    end

endmodule
`default_nettype wire

//--- drive_state_io_indicator_sva.sv
// Purpose: port assertions for the drive state indicator
// Assumes: status output functions stay factory until rewritten
// Notes:   pin-to-state windows allow for the input synchroniser
`timescale 1ns/10ps
`default_nettype none
module drive_state_io_indicator_sva (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    input  wire logic       i_enable_pin,
    input  wire logic       i_fault_reset_pin,
    input  wire logic       i_enable_fn_assigned,
    input  wire logic       i_fault_reset_fn_assigned,
    input  wire logic       i_panel_error_reset,
    input  wire logic       i_error_class23,
    input  wire logic       i_disable_reaction_select,
    input  wire logic       i_out_fn_write,
    input  wire logic       o_status_output_zero,
    input  wire logic       o_status_output_one,
    input  wire logic       o_power_stage_on,
    input  wire logic       o_halt_active,
    input  wire logic [3:0] o_op_state
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // state decode; function rewrite ends the factory checks
    wire in_sod = o_op_state == drive_state_io_pkg::ST_SW_ON_DIS;
    wire in_rdy = o_op_state == drive_state_io_pkg::ST_READY;
    wire in_son = o_op_state == drive_state_io_pkg::ST_SWITCHED_ON;
    wire in_run = o_op_state == drive_state_io_pkg::ST_OP_ENABLED;
    wire in_qs  = o_op_state == drive_state_io_pkg::ST_QUICK_STOP;
    wire in_flt = o_op_state == drive_state_io_pkg::ST_FAULT;
    logic fn_moved_r;
    always_ff @(posedge i_clk_sys) begin
        fn_moved_r <= i_reset ? 1'b0 : (fn_moved_r | i_out_fn_write);
    end
    sequence s_ena_rise;
        i_enable_fn_assigned && $rose(i_enable_pin);
    endsequence
    sequence s_ena_fall;
        i_enable_fn_assigned && $fell(i_enable_pin);
    endsequence
    sequence s_frs_rise;
        i_fault_reset_fn_assigned && $rose(i_fault_reset_pin);
    endsequence
    property p_no_fault;
        !fn_moved_r |-> o_status_output_zero == (in_rdy | in_son | in_run);
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("no-fault output bad");
    property p_active;
        !fn_moved_r |-> o_status_output_one == in_run;
    endproperty
    a_active: assert property (p_active)
        else $error("active output bad");
    property p_panel_qs;
        in_qs && i_panel_error_reset && !i_error_class23 |=> in_run;
    endproperty
    a_panel_qs: assert property (p_panel_qs) else $error("no resume");
    property p_panel_flt;
        in_flt && i_panel_error_reset && !i_error_class23 |=> in_sod;
    endproperty
    a_panel_flt: assert property (p_panel_flt) else $error("no clear");
    property p_ena_rise; in_rdy ##0 s_ena_rise |-> ##[2:6] in_run; endproperty
    a_ena_rise: assert property (p_ena_rise) else $error("no enable");
    property p_ena_unassigned;
        in_rdy && !i_enable_fn_assigned && $rose(i_enable_pin)
        ##1 (!i_enable_fn_assigned && !i_error_class23) [*6] |-> in_rdy;
    endproperty
    a_ena_unassigned: assert property (p_ena_unassigned)
        else $error("stray");
    property p_frs_rise; in_flt ##0 s_frs_rise |-> ##[2:6] in_sod; endproperty
    a_frs_rise: assert property (p_frs_rise) else $error("fault kept");
    property p_frs_unassigned;
        in_qs && !i_fault_reset_fn_assigned && $rose(i_fault_reset_pin)
        ##1 (!i_fault_reset_fn_assigned && !i_panel_error_reset) [*6] |-> in_qs;
    endproperty
    a_frs_unassigned: assert property (p_frs_unassigned)
        else $error("stray");
    property p_qs_cut;
        in_qs ##0 s_ena_fall |-> ##[2:6] (in_sod && !o_power_stage_on);
    endproperty
    a_qs_cut: assert property (p_qs_cut)
        else $error("quick stop kept");
    property p_halt;
        in_run && i_disable_reaction_select ##0 s_ena_fall
        |-> ##[2:6] (o_halt_active && o_power_stage_on);
    endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_cut;
        in_run && !i_disable_reaction_select ##0 s_ena_fall
        |-> ##[2:6] (in_sod && !o_power_stage_on);
    endproperty
    a_cut: assert property (p_cut) else $error("no cut");
endmodule
bind drive_state_io_indicator drive_state_io_indicator_sva u_sva (
    .i_clk_sys, .i_reset, .i_enable_pin, .i_fault_reset_pin,
    .i_enable_fn_assigned, .i_fault_reset_fn_assigned, .i_panel_error_reset,
    .i_error_class23, .i_disable_reaction_select, .i_out_fn_write,
    .o_status_output_zero, .o_status_output_one, .o_power_stage_on,
    .o_halt_active, .o_op_state);
`default_nettype wire

//--- drive_state_io_indicator_test.sv
// Purpose: self-checking bench for the drive state indicator
// Assumes: inputs move on the falling edge, notes checked in order
// Notes:   state words pack both status outputs above the state
`timescale 1ns/10ps
`default_nettype none
module drive_state_io_indicator_test;
    localparam logic [15:0] CFG_A = drive_state_io_pkg::ENA_FRES_CFG_OFFSET;
    typedef struct { string name; logic [15:0] exp; bit reg_kind; } note_t;
    note_t notes[$];
    int   checks = 0, miscompares = 0, seed = 15228;
    logic [31:0] rnd;
    logic clk_sys = 1'b0, reset = 1'b1, look = 1'b0, slow = 1'b0;
    logic want_ena = 1'b0, want_frs = 1'b0, asg_ena = 1'b1, asg_frs = 1'b1;
    logic panel = 1'b0, err1 = 1'b0, err23 = 1'b0, react_done = 1'b0;
    logic init_done = 1'b0, ready_req = 1'b0, halt_done = 1'b0, clk_en = 1'b1;
    logic dis_sel = 1'b0, fn_write = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [1:0]  zero_fn = 2'h0, one_fn = 2'h1;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, rdata;
    logic ena_pin, frs_pin, ena_fn, frs_fn, st0, st1;
    logic [3:0] state;
    wire  [15:0] seen_st = {10'h000, st0, st1, state};
    always #5 clk_sys = ~clk_sys;
    io_controller_model u_io_controller_model (.i_clk(clk_sys),
        .i_slow(slow), .i_want_enable(want_ena), .i_want_fault_reset(want_frs),
        .i_assign_enable(asg_ena), .i_assign_fault_reset(asg_frs),
        .o_enable_pin(ena_pin), .o_fault_reset_pin(frs_pin),
        .o_enable_fn_assigned(ena_fn), .o_fault_reset_fn_assigned(frs_fn));
    drive_state_io_indicator u_drive_state_io_indicator (.i_clk_sys(clk_sys),
        .i_reset(reset), .i_clk_en(clk_en), .i_enable_pin(ena_pin),
        .i_fault_reset_pin(frs_pin), .i_enable_fn_assigned(ena_fn),
        .i_fault_reset_fn_assigned(frs_fn), .i_panel_error_reset(panel),
        .i_error_class1(err1), .i_error_class23(err23),
        .i_fault_react_done(react_done), .i_init_done(init_done),
        .i_ready_request(ready_req), .i_halt_done(halt_done),
        .i_disable_reaction_select(dis_sel), .i_out_zero_fn(zero_fn),
        .i_out_one_fn(one_fn), .i_out_fn_write(fn_write),
        .i_reg_write(reg_write), .i_reg_read(reg_read), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
        .o_status_output_zero(st0), .o_status_output_one(st1),
        .o_power_stage_on(), .o_halt_active(), .o_op_state(state));
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // monitor: oldest note against whatever output it names
    always @(posedge clk_sys) begin
        if (look && notes.size() > 0) begin
            automatic note_t n = notes.pop_front();
            check(n.name, n.reg_kind ? rdata : seen_st, n.exp);
        end
    end
    task automatic note(string name, logic [15:0] exp, bit reg_kind);
        notes.push_back('{name, exp, reg_kind});
        @(negedge clk_sys) look = 1'b1;
        @(negedge clk_sys) look = 1'b0;
    endtask
    // expected status word worked out from the state alone
    task automatic see(logic [3:0] s);
        repeat (10) @(negedge clk_sys);
        note("state", {10'h000, s inside {4'h4, 4'h5, 4'h6}, s == 4'h6, s}, 0);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys) s = 1'b1;
        @(negedge clk_sys) s = 1'b0;
    endtask
    task automatic reg_wr(logic [15:0] a, logic [15:0] d);
        @(negedge clk_sys) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
        @(negedge clk_sys) reg_write = 1'b0;
    endtask
    task automatic reg_rd(logic [15:0] a, logic [15:0] d);
        @(negedge clk_sys) {reg_addr, reg_read} = {a, 1'b1};
        @(negedge clk_sys) reg_read = 1'b0;
        note("reg", d, 1);
    endtask
    // ready, fresh enable edge, then into operation
    task automatic to_run();
        pulse(ready_req);
        want_ena = 1'b0;
        repeat (10) @(negedge clk_sys);
        want_ena = 1'b1;
        see(4'h6);
    endtask
    task automatic to_fault();
        pulse(err23);
        pulse(react_done);
        see(4'h9);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        reg_rd(CFG_A, 16'h0000);
        rnd = $random(seed);
        reg_wr(16'h0570, rnd[15:0]);
        reg_rd(16'h0570, 16'h0000);
        reg_wr(CFG_A, {14'h0, drive_state_io_pkg::RESET_ON_RISE});
        reg_rd(CFG_A, {14'h0, drive_state_io_pkg::RESET_ON_RISE});
        init_done = 1'b1;
        see(4'h3);
        pulse(ready_req);
        asg_ena = 1'b0;
        want_ena = 1'b1;
        see(4'h4);
        asg_ena = 1'b1;
        to_run();
        pulse(err1);
        asg_frs = 1'b0;
        want_frs = 1'b1;
        see(4'h7);
        want_frs = 1'b0;
        see(4'h7);
        asg_frs = 1'b1;
        want_frs = 1'b1;
        see(4'h6);
        want_frs = 1'b0;
        pulse(err1);
        pulse(panel);
        see(4'h6);
        pulse(err1);
        want_ena = 1'b0;
        see(4'h3);
        to_run();
        reg_wr(CFG_A, {14'h0, drive_state_io_pkg::RESET_ON_FALL});
        to_fault();
        want_ena = 1'b0;
        see(4'h9);
        want_ena = 1'b1;
        see(4'h3);
        to_run();
        to_fault();
        pulse(panel);
        see(4'h3);
        to_run();
        to_fault();
        want_frs = 1'b1;
        see(4'h3);
        want_frs = 1'b0;
        to_run();
        to_fault();
        want_ena = 1'b0;
        see(4'h3);
        reg_wr(CFG_A, {14'h0, drive_state_io_pkg::FRES_OFF});
        to_run();
        to_fault();
        want_ena = 1'b0;
        see(4'h9);
        pulse(panel);
        {slow, dis_sel} = 2'b11;
        to_run();
        want_ena = 1'b0;
        see(4'h6);
        pulse(halt_done);
        see(4'h3);
        {slow, dis_sel} = 2'b00;
        to_run();
        want_ena = 1'b0;
        see(4'h3);
        {zero_fn, one_fn} = {drive_state_io_pkg::OUT_FN_ACTIVE, 2'h0};
        pulse(fn_write);
        pulse(ready_req);
        repeat (10) @(negedge clk_sys);
        note("swapped", 16'h0014, 0);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        see(4'h3);
        // frozen by the clock enable, a ready request must be lost
        clk_en = 1'b0;
        pulse(ready_req);
        see(4'h3);
        clk_en = 1'b1;
        pulse(ready_req);
        see(4'h4);
        finish_test();
    end
endmodule
`default_nettype wire

//--- drive_state_io_pkg.sv
// Purpose: shared constants and types for the drive state indicator
// Assumes: one system clock, synchronous reset
// Notes:   operating states keep their documented numbering
package drive_state_io_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [15:0] ENA_FRES_CFG_OFFSET = 16'h0568;
    localparam logic [15:0] ENA_FRES_CFG_RESET  = 16'h0000;
    localparam int          ENA_FRES_SEL_LSB    = 0;
    localparam int          ENA_FRES_SEL_MSB    = 1;

    // enable-input fault reset selections
    localparam logic [1:0]  FRES_OFF            = 2'h0;
    localparam logic [1:0]  RESET_ON_FALL       = 2'h1;
    localparam logic [1:0]  RESET_ON_RISE       = 2'h2;

    // disable reaction selections
    localparam logic        DISABLE_IMMEDIATE   = 1'h0;
    localparam logic        DISABLE_AFTER_HALT  = 1'h1;

    // status output function codes
    localparam logic [1:0]  OUT_FN_NO_FAULT     = 2'h0;
    localparam logic [1:0]  OUT_FN_ACTIVE       = 2'h1;
    localparam logic [1:0]  OUT_FN_OFF          = 2'h2;
    localparam logic [1:0]  OUT_ZERO_FN_RESET   = 2'h0;
    localparam logic [1:0]  OUT_ONE_FN_RESET    = 2'h1;

    // ----------------------------------------------------------------
    // operating states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_START        = 4'h1,
        ST_NOT_READY    = 4'h2,
        ST_SW_ON_DIS    = 4'h3,
        ST_READY        = 4'h4,
        ST_SWITCHED_ON  = 4'h5,
        ST_OP_ENABLED   = 4'h6,
        ST_QUICK_STOP   = 4'h7,
        ST_FAULT_REACT  = 4'h8,
        ST_FAULT        = 4'h9
    } op_state_t;

endpackage

//--- io_controller_model.sv
// Purpose: external controller wired to the enable and fault-reset pins
// Assumes: bench says what it wants; model adds its wiring lag
// Notes:   slow mode lags three cycles, prompt mode one
`timescale 1ns/10ps
`default_nettype none
module io_controller_model (
    input  wire logic i_clk,
    input  wire logic i_slow,
    input  wire logic i_want_enable,
    input  wire logic i_want_fault_reset,
    input  wire logic i_assign_enable,
    input  wire logic i_assign_fault_reset,
    output logic      o_enable_pin,
    output logic      o_fault_reset_pin,
    output logic      o_enable_fn_assigned,
    output logic      o_fault_reset_fn_assigned
);
    logic [2:0] ena_dly_r = 3'h0;
    logic [2:0] frs_dly_r = 3'h0;
    logic       ena_pin_r = 1'b0;
    logic       frs_pin_r = 1'b0;
    // functions assigned at once while pins lag, so the assignment
    // always lands before the edge it qualifies
    assign o_enable_fn_assigned      = i_assign_enable;
    assign o_fault_reset_fn_assigned = i_assign_fault_reset;
    // wishes sampled on the rising edge, pins move on the falling one
    always @(posedge i_clk) begin
        ena_dly_r <= {ena_dly_r[1:0], i_want_enable};
        frs_dly_r <= {frs_dly_r[1:0], i_want_fault_reset};
    end
    // fault reset is only wished once the error cause is gone
    always @(negedge i_clk) begin
        ena_pin_r <= i_slow ? ena_dly_r[2] : ena_dly_r[0];
        frs_pin_r <= i_slow ? frs_dly_r[2] : frs_dly_r[0];
    end
    assign o_enable_pin      = ena_pin_r;
    assign o_fault_reset_pin = frs_pin_r;
endmodule
`default_nettype wire
